//--- include/fswp_pkg.sv
// Package for the flash status and write-protection block: command
// codes, status bit positions, reset values and state encoding.
// Assumes a command decoder outside that turns serial frames into pulses.
package fswp_pkg;

  // Command codes presented on cmd_code with a one-cycle cmd_valid
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_WRITE_UNLOCK = 3'h1;
  localparam logic [2:0] CMD_WRITE_LOCK = 3'h2;
  localparam logic [2:0] CMD_STATUS_WRITE = 3'h3;
  localparam logic [2:0] CMD_PAGE_WRITE = 3'h4;
  localparam logic [2:0] CMD_FOUR_KB_WIPE = 3'h5;
  localparam logic [2:0] CMD_BLOCK_WIPE = 3'h6;
  localparam logic [2:0] CMD_CHIP_WIPE = 3'h7;

  // Status register selectors for a status write
  localparam logic [1:0] SEL_LOW = 2'h1;
  localparam logic [1:0] SEL_MID = 2'h2;
  localparam logic [1:0] SEL_HIGH = 2'h3;

  // Bit positions inside the low status byte
  localparam int LOW_LOCK_MODE_LOW = 7;
  localparam int LOW_BP_MSB = 6;
  localparam int LOW_BP_LSB = 2;
  localparam int LOW_WEL = 1;
  localparam int LOW_BUSY = 0;
  // Bit positions inside the mid status byte
  localparam int MID_ERASE_PAUSED = 7;
  localparam int MID_COMPLEMENT = 6;
  localparam int MID_LOCK_MSB = 5;
  localparam int MID_LOCK_LSB = 3;
  localparam int MID_PROG_PAUSED = 2;
  localparam int MID_QUAD = 1;
  localparam int MID_LOCK_MODE_HIGH = 0;
  // Bit positions inside the high status byte
  localparam int HIGH_PIN_FUNC = 7;
  localparam int HIGH_STRENGTH_MSB = 6;
  localparam int HIGH_STRENGTH_LSB = 5;
  localparam int HIGH_DUMMY = 0;

  // Power-on values of the stored fields
  localparam logic [4:0] BP_RESET = 5'h00;
  localparam logic [2:0] SEC_LOCK_RESET = 3'h0;
  localparam logic [1:0] STRENGTH_RESET = 2'h1;
  localparam logic [1:0] LOCK_MODE_RESET = 2'h0;

  // Lock mode codes {high, low}
  localparam logic [1:0] LOCK_SOFTWARE = 2'h0;
  localparam logic [1:0] LOCK_PIN = 2'h1;
  localparam logic [1:0] LOCK_POWER = 2'h2;
  localparam logic [1:0] LOCK_FOREVER = 2'h3;

  // Protection geometry: 16 MB array, granules of 256 KB and 4 KB
  localparam int ADDR_W = 24;
  localparam logic [4:0] EXP_LARGE = 5'h12;
  localparam logic [4:0] EXP_SMALL = 5'h0c;
  localparam logic [2:0] SMALL_SHIFT_MAX = 3'h3;
  localparam logic [2:0] BP_CODE_NONE = 3'h0;
  localparam logic [2:0] BP_CODE_ALL = 3'h7;

  // One-hot engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARRAY = 3'b010,
    ST_STATUS = 3'b100
  } fswp_state_t;

endpackage

//--- design/fswp_range.sv
// Guarded-range decoder: tells whether one array address lies in the area
// selected by the block-protect field and the complement bit.
// Purely combinational; the caller registers whatever it keeps.
module fswp_range
  import fswp_pkg::*;
(
  // Protection settings
  input wire logic [4:0] block_protect_field,
  input wire logic complement_protect,
  // Address under test
  input wire logic [ADDR_W-1:0] addr,
  // Verdicts
  output logic guarded,
  output logic chip_wipe_ok
);

  logic [2:0] code;
  logic [2:0] shift;
  logic [4:0] size_exp;
  logic [ADDR_W-1:0] mask;
  logic base_hit;

  // Range with complement clear, then inverted when complement is set
  always_comb begin
    code = block_protect_field[2:0];
    shift = code - 3'h1;
    if (block_protect_field[4] && shift > SMALL_SHIFT_MAX) begin
      shift = SMALL_SHIFT_MAX; // 32 KB tops out the small granule
    end
    size_exp = (block_protect_field[4] ? EXP_SMALL : EXP_LARGE) +
               {2'h0, shift};
    mask = ~((24'h000001 << size_exp) - 24'h000001);
    if (code == BP_CODE_NONE) begin
      base_hit = 1'b0;
    end else if (code == BP_CODE_ALL) begin
      base_hit = 1'b1;
    end else if (block_protect_field[3]) begin
      base_hit = ((addr & mask) == 24'h000000);
    end else begin
      base_hit = ((addr & mask) == mask);
    end
    guarded = base_hit ^ complement_protect;
  end

  // Chip erase only with nothing guarded
  assign chip_wipe_ok = (code == BP_CODE_NONE && !complement_protect) ||
                        (code == BP_CODE_ALL && complement_protect);

endmodule

//--- design/fswp_core.sv
// Status registers and write-protection gate of a serial NOR flash.
// Assumes a command decoder that delivers whole, byte-aligned commands as
// one-cycle pulses, and an array engine that reports completion.
//
// Function
// - complement bit inverts the guarded range
// - low status byte layout, read-only busy/latch
// - mid status byte layout, paused flags read-only
// - high status byte layout, reserved bits
// - busy flag high during program/erase/status write
// - latch clear rejects all write commands
// - refuse program/erase inside guarded range
// - no protect changes under hardware protection
// - chip erase only when nothing guarded
// - lock mode 00 allows writes after latch
// - lock mode 01 follows write-protect pin
// - lock mode 10 blocks until power cycle
// - lock mode 11 blocks status writes forever
// - quad enable turns control pins into data
// - latch cleared by power, reset, completions
// - block-protect field selects guarded range
// - security lock bits are set-only
module fswp_core
  import fswp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Commands from the decoder
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [1:0] cmd_sel,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  // Command verdicts
  output logic cmd_accepted,
  output logic cmd_refused,
  // Array engine
  output logic op_start,
  output logic [2:0] op_code,
  output logic [ADDR_W-1:0] op_addr,
  input wire logic op_done,
  // Power, reset and suspend events
  input wire logic power_cycle,
  input wire logic soft_reset,
  input wire logic erase_suspend,
  input wire logic program_suspend,
  input wire logic op_resume,
  // Pin states
  input wire logic wp_n,
  output logic wp_pin_is_data,
  output logic hold_pin_is_data,
  output logic hold_pin_is_reset,
  // Status bytes
  output logic [7:0] status_protect_low,
  output logic [7:0] status_protect_mid,
  output logic [7:0] status_config_high,
  // Decoded settings for the rest of the device
  output logic [2:0] security_lock,
  output logic [1:0] output_strength,
  output logic dummy_cycle_select
);

  fswp_state_t state_q, state_d;
  logic write_enable_latch_q, write_enable_latch_d;
  logic [4:0] block_protect_field_q, block_protect_field_d;
  logic lock_mode_high_q, lock_mode_high_d;
  logic lock_mode_low_q, lock_mode_low_d;
  logic complement_protect_q, complement_protect_d;
  logic quad_io_enable_q, quad_io_enable_d;
  logic [2:0] sec_lock_q, sec_lock_d;
  logic erase_paused_flag_q, erase_paused_flag_d;
  logic program_paused_flag_q, program_paused_flag_d;
  logic pin_func_q, pin_func_d;
  logic [1:0] strength_q, strength_d;
  logic dummy_q, dummy_d;
  logic [1:0] pend_sel_q, pend_sel_d;
  logic [7:0] pend_data_q, pend_data_d;
  logic accepted_q, accepted_d;
  logic refused_q, refused_d;
  logic start_q, start_d;
  logic [2:0] op_code_q, op_code_d;
  logic [ADDR_W-1:0] op_addr_q, op_addr_d;

  logic guarded;
  logic chip_wipe_ok;
  logic [1:0] lock_mode;
  logic wp_eff_n;
  logic status_write_ok;
  logic write_busy_flag;
  logic is_write_cmd;

  // Address check on the full incoming address
  fswp_range u_range (
    .block_protect_field(block_protect_field_q),
    .complement_protect(complement_protect_q),
    .addr(cmd_addr),
    .guarded(guarded),
    .chip_wipe_ok(chip_wipe_ok)
  );

  // Pin roles follow quad enable; a data pin never acts as write-protect
  assign wp_eff_n = quad_io_enable_q | wp_n;
  assign wp_pin_is_data = quad_io_enable_q;
  assign hold_pin_is_data = quad_io_enable_q;
  assign hold_pin_is_reset = !quad_io_enable_q && pin_func_q;

  // Status write gate by lock mode
  assign lock_mode = {lock_mode_high_q, lock_mode_low_q};
  always_comb begin
    case (lock_mode)
      LOCK_SOFTWARE: status_write_ok = 1'b1;
      LOCK_PIN: status_write_ok = wp_eff_n;
      LOCK_POWER: status_write_ok = 1'b0;
      LOCK_FOREVER: status_write_ok = 1'b0;
      default: status_write_ok = 1'b0;
    endcase
  end

  assign write_busy_flag = (state_q != ST_IDLE);
  assign is_write_cmd = (cmd_code == CMD_STATUS_WRITE) ||
                        (cmd_code == CMD_PAGE_WRITE) ||
                        (cmd_code == CMD_FOUR_KB_WIPE) ||
                        (cmd_code == CMD_BLOCK_WIPE) ||
                        (cmd_code == CMD_CHIP_WIPE);

  // Command acceptance, engine sequencing and status field updates
  always_comb begin
    state_d = state_q;
    write_enable_latch_d = write_enable_latch_q;
    block_protect_field_d = block_protect_field_q;
    lock_mode_high_d = lock_mode_high_q;
    lock_mode_low_d = lock_mode_low_q;
    complement_protect_d = complement_protect_q;
    quad_io_enable_d = quad_io_enable_q;
    sec_lock_d = sec_lock_q;
    erase_paused_flag_d = erase_paused_flag_q;
    program_paused_flag_d = program_paused_flag_q;
    pin_func_d = pin_func_q;
    strength_d = strength_q;
    dummy_d = dummy_q;
    pend_sel_d = pend_sel_q;
    pend_data_d = pend_data_q;
    accepted_d = 1'b0;
    refused_d = 1'b0;
    start_d = 1'b0;
    op_code_d = op_code_q;
    op_addr_d = op_addr_q;
    // Suspend flags: resume clears, a suspend in the same cycle wins
    if (op_resume) begin
      erase_paused_flag_d = 1'b0;
      program_paused_flag_d = 1'b0;
    end
    if (erase_suspend) begin
      erase_paused_flag_d = 1'b1;
    end
    if (program_suspend) begin
      program_paused_flag_d = 1'b1;
    end
    case (state_q)
      ST_IDLE: begin
        if (cmd_valid && cmd_code == CMD_WRITE_UNLOCK) begin
          write_enable_latch_d = 1'b1;
          accepted_d = 1'b1;
        end else if (cmd_valid && cmd_code == CMD_WRITE_LOCK) begin
          write_enable_latch_d = 1'b0;
          accepted_d = 1'b1;
        end else if (cmd_valid && is_write_cmd) begin
          if (!write_enable_latch_q) begin
            refused_d = 1'b1;
          end else if (cmd_code == CMD_STATUS_WRITE) begin
            if (status_write_ok && cmd_sel != 2'h0) begin
              pend_sel_d = cmd_sel;
              pend_data_d = cmd_data;
              state_d = ST_STATUS;
              accepted_d = 1'b1;
            end else begin
              refused_d = 1'b1;
            end
          end else if (cmd_code == CMD_CHIP_WIPE ? !chip_wipe_ok
                                                 : guarded) begin
            refused_d = 1'b1;
          end else begin
            start_d = 1'b1;
            op_code_d = cmd_code;
            op_addr_d = cmd_addr;
            state_d = ST_ARRAY;
            accepted_d = 1'b1;
          end
        end else if (cmd_valid && cmd_code != CMD_NOP) begin
          refused_d = 1'b1;
        end
      end
      ST_ARRAY: begin
        if (cmd_valid) begin
          refused_d = 1'b1; // Busy: the engine owns the array
        end
        if (op_done) begin
          write_enable_latch_d = 1'b0;
          state_d = ST_IDLE;
        end
      end
      ST_STATUS: begin
        if (cmd_valid) begin
          refused_d = 1'b1;
        end
        // New value lands when the non-volatile write completes
        if (op_done) begin
          write_enable_latch_d = 1'b0;
          state_d = ST_IDLE;
          case (pend_sel_q)
            SEL_LOW: begin
              lock_mode_low_d = pend_data_q[LOW_LOCK_MODE_LOW];
              block_protect_field_d =
                pend_data_q[LOW_BP_MSB:LOW_BP_LSB];
            end
            SEL_MID: begin
              complement_protect_d = pend_data_q[MID_COMPLEMENT];
              sec_lock_d = sec_lock_q |
                pend_data_q[MID_LOCK_MSB:MID_LOCK_LSB];
              quad_io_enable_d = pend_data_q[MID_QUAD];
              lock_mode_high_d = pend_data_q[MID_LOCK_MODE_HIGH];
            end
            SEL_HIGH: begin
              pin_func_d = pend_data_q[HIGH_PIN_FUNC];
              strength_d =
                pend_data_q[HIGH_STRENGTH_MSB:HIGH_STRENGTH_LSB];
              dummy_d = pend_data_q[HIGH_DUMMY];
            end
            default: begin
              state_d = ST_IDLE;
            end
          endcase
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Power cycle and software reset end work and drop volatile bits
    if (power_cycle || soft_reset) begin
      state_d = ST_IDLE;
      write_enable_latch_d = 1'b0;
      erase_paused_flag_d = 1'b0;
      program_paused_flag_d = 1'b0;
      start_d = 1'b0;
    end
    // Supply lock-down lasts only until the next power cycle
    if (power_cycle && lock_mode == LOCK_POWER) begin
      lock_mode_high_d = 1'b0;
      lock_mode_low_d = 1'b0;
    end
  end

  // Registers; non-volatile fields start at their delivery values
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      write_enable_latch_q <= 1'b0;
      block_protect_field_q <= BP_RESET;
      lock_mode_high_q <= LOCK_MODE_RESET[1];
      lock_mode_low_q <= LOCK_MODE_RESET[0];
      complement_protect_q <= 1'b0;
      quad_io_enable_q <= 1'b0;
      sec_lock_q <= SEC_LOCK_RESET;
      erase_paused_flag_q <= 1'b0;
      program_paused_flag_q <= 1'b0;
      pin_func_q <= 1'b0;
      strength_q <= STRENGTH_RESET;
      dummy_q <= 1'b0;
      pend_sel_q <= 2'h0;
      pend_data_q <= 8'h00;
      accepted_q <= 1'b0;
      refused_q <= 1'b0;
      start_q <= 1'b0;
      op_code_q <= CMD_NOP;
      op_addr_q <= 24'h000000;
    end else begin
      state_q <= state_d;
      write_enable_latch_q <= write_enable_latch_d;
      block_protect_field_q <= block_protect_field_d;
      lock_mode_high_q <= lock_mode_high_d;
      lock_mode_low_q <= lock_mode_low_d;
      complement_protect_q <= complement_protect_d;
      quad_io_enable_q <= quad_io_enable_d;
      sec_lock_q <= sec_lock_d;
      erase_paused_flag_q <= erase_paused_flag_d;
      program_paused_flag_q <= program_paused_flag_d;
      pin_func_q <= pin_func_d;
      strength_q <= strength_d;
      dummy_q <= dummy_d;
      pend_sel_q <= pend_sel_d;
      pend_data_q <= pend_data_d;
      accepted_q <= accepted_d;
      refused_q <= refused_d;
      start_q <= start_d;
      op_code_q <= op_code_d;
      op_addr_q <= op_addr_d;
    end
  end

  // Outputs
  assign cmd_accepted = accepted_q;
  assign cmd_refused = refused_q;
  assign op_start = start_q;
  assign op_code = op_code_q;
  assign op_addr = op_addr_q;
  assign security_lock = sec_lock_q;
  assign output_strength = strength_q;
  assign dummy_cycle_select = dummy_q;

  // Status byte images, assembled from flops only
  assign status_protect_low = {lock_mode_low_q, block_protect_field_q,
                               write_enable_latch_q,
                               write_busy_flag};
  assign status_protect_mid = {erase_paused_flag_q, complement_protect_q,
                               sec_lock_q, program_paused_flag_q,
                               quad_io_enable_q, lock_mode_high_q};
  assign status_config_high = {pin_func_q, strength_q, 4'h0,
                               dummy_q};

endmodule

//--- verif/fswp_core_assertions.sv
// Concurrent checks on the status and write-protection block's ports.
// Bound to every fswp_core instance; the package is compiled first.
module fswp_core_assertions
  import fswp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Commands, verdicts and engine
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic cmd_accepted,
  input wire logic cmd_refused,
  input wire logic op_start,
  input wire logic op_done,
  // Events and pins
  input wire logic power_cycle,
  input wire logic soft_reset,
  input wire logic wp_n,
  input wire logic wp_pin_is_data,
  input wire logic hold_pin_is_data,
  input wire logic hold_pin_is_reset,
  // Status bytes
  input wire logic [7:0] status_protect_low,
  input wire logic [7:0] status_protect_mid,
  input wire logic [7:0] status_config_high
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Short names for the fields the properties lean on
  wire logic busy = status_protect_low[0];
  wire logic latch = status_protect_low[1];
  wire logic quad = status_protect_mid[1];
  wire logic cmp = status_protect_mid[6];
  wire logic [2:0] bp = status_protect_low[4:2];
  wire logic [1:0] mode = {status_protect_mid[0], status_protect_low[7]};

  // Status write taken while idle under one lock mode
  sequence s_sw(logic [1:0] m);
    cmd_valid && cmd_code == CMD_STATUS_WRITE && !busy && mode == m;
  endsequence
  // Refusal that leaves the engine idle
  sequence s_refuse;
    cmd_refused && !busy;
  endsequence

  answer_once_a: assert property (cmd_valid && cmd_code != CMD_NOP
    |=> cmd_accepted != cmd_refused) else $error("no single verdict");
  latch_gate_a: assert property (cmd_valid && !latch
    && cmd_code >= CMD_STATUS_WRITE |=> cmd_refused)
    else $error("write taken without latch");
  start_pair_a: assert property (op_start |-> cmd_accepted && busy)
    else $error("start without accept and busy");
  done_clears_a: assert property (busy && op_done |=> !busy && !latch)
    else $error("completion left busy or latch");
  unlock_sets_a: assert property (cmd_valid && cmd_code == CMD_WRITE_UNLOCK
    && !busy && !power_cycle && !soft_reset |=> latch && cmd_accepted)
    else $error("unlock did not set latch");
  pin_lock_a: assert property (s_sw(LOCK_PIN) ##0 (!wp_n && !quad)
    |=> s_refuse) else $error("write passed low protect pin");
  power_lock_a: assert property (s_sw(LOCK_POWER) |=> s_refuse)
    else $error("write passed power lock");
  forever_lock_a: assert property (s_sw(LOCK_FOREVER) |=> s_refuse)
    else $error("write passed permanent lock");
  power_clear_a: assert property (power_cycle && mode == LOCK_POWER
    |=> mode == LOCK_SOFTWARE && !latch) else $error("power lock kept");
  chip_gate_a: assert property (cmd_valid && cmd_code == CMD_CHIP_WIPE
    && !((bp == 3'h0 && !cmp) || (bp == 3'h7 && cmp)) |=> cmd_refused)
    else $error("chip wipe taken while guarded");
  quad_pins_a: assert property (wp_pin_is_data == quad
    && hold_pin_is_data == quad
    && hold_pin_is_reset == (!quad && status_config_high[7]))
    else $error("pin roles do not follow quad bit");
  reserved_zero_a: assert property (status_config_high[4:1] == 4'h0)
    else $error("reserved bits set");
  sec_sticky_a: assert property (($past(status_protect_mid[5:3])
    & ~status_protect_mid[5:3]) == 3'h0) else $error("lock bit cleared");
endmodule

bind fswp_core fswp_core_assertions chk_u (.clk(clk), .nrst(nrst),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_accepted(cmd_accepted),
  .cmd_refused(cmd_refused), .op_start(op_start), .op_done(op_done),
  .power_cycle(power_cycle), .soft_reset(soft_reset), .wp_n(wp_n),
  .wp_pin_is_data(wp_pin_is_data), .hold_pin_is_data(hold_pin_is_data),
  .hold_pin_is_reset(hold_pin_is_reset),
  .status_protect_low(status_protect_low),
  .status_protect_mid(status_protect_mid),
  .status_config_high(status_config_high));

//--- verif/fswp_engine_model.sv
// Array engine stand-in: ends every busy operation after lat+1 cycles.
// Assumes busy rises the cycle after an accepted program, erase or write.
module fswp_engine_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Busy flag and chosen latency
  input wire logic busy,
  input wire logic [7:0] lat,
  // Completion pulse
  output logic op_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] cnt_q;

  // One pulse per busy span; the count parks until busy drops again
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 9'h000;
      op_done <= 1'b0;
    end else begin
      op_done <= busy && cnt_q == {1'b0, lat};
      if (!busy) cnt_q <= 9'h000;
      else if (cnt_q <= {1'b0, lat}) cnt_q <= cnt_q + 9'h001;
    end
  end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the status and write-protection block.
// Commands are driven 1 ns after a rising edge; the engine model answers.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench
  import fswp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, wp_n = 1'b1;
  logic power_cycle = 1'b0, soft_reset = 1'b0, op_resume = 1'b0;
  logic erase_suspend = 1'b0, program_suspend = 1'b0;
  logic [2:0] cmd_code = 3'h0;
  logic [1:0] cmd_sel = 2'h0;
  logic [23:0] cmd_addr = 24'h0;
  logic [7:0] cmd_data = 8'h00, lat = 8'h02;
  logic cmd_accepted, cmd_refused, op_start, op_done, wp_pin_is_data;
  logic hold_pin_is_data, hold_pin_is_reset, dummy_cycle_select;
  logic [2:0] op_code, security_lock;
  logic [1:0] output_strength;
  logic [23:0] op_addr;
  logic [7:0] status_protect_low, status_protect_mid, status_config_high;
  int fails = 0;
  int n_checks = 0;

  fswp_core dut_u (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_accepted(cmd_accepted),
    .cmd_refused(cmd_refused), .op_start(op_start), .op_code(op_code),
    .op_addr(op_addr), .op_done(op_done), .power_cycle(power_cycle),
    .soft_reset(soft_reset), .erase_suspend(erase_suspend),
    .program_suspend(program_suspend), .op_resume(op_resume), .wp_n(wp_n),
    .wp_pin_is_data(wp_pin_is_data), .hold_pin_is_data(hold_pin_is_data),
    .hold_pin_is_reset(hold_pin_is_reset),
    .status_protect_low(status_protect_low),
    .status_protect_mid(status_protect_mid),
    .status_config_high(status_config_high), .security_lock(security_lock),
    .output_strength(output_strength),
    .dummy_cycle_select(dummy_cycle_select));
  fswp_engine_model eng_u (.clk(clk), .nrst(nrst),
    .busy(status_protect_low[0]), .lat(lat), .op_done(op_done));

  // 10 MHz clock
  always #50 clk = ~clk;

  // One command pulse; the verdict is read once the taking edge settles
  task automatic cmd(input logic [2:0] c, input logic [1:0] s,
    input logic [23:0] a, input logic [7:0] d, output logic ok);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_sel = s;
    cmd_addr = a;
    cmd_data = d;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    ok = cmd_accepted;
  endtask

  // Bounded wait for the busy flag to drop
  task automatic idle();
    repeat (60) if (status_protect_low[0] !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    `CHK(status_protect_low[0], 1'b0)
  endtask

  task automatic pulse(ref logic s);
    @(posedge clk);
    #1;
    s = 1'b1;
    @(posedge clk);
    #1;
    s = 1'b0;
  endtask

  // Unlock, then write one status byte and expect the verdict
  task automatic sw(input logic [1:0] s, input logic [7:0] d, input logic e);
    logic ok;
    cmd(CMD_WRITE_UNLOCK, 2'h0, 24'h0, 8'h00, ok);
    cmd(CMD_STATUS_WRITE, s, 24'h0, d, ok);
    `CHK(ok, e)
    idle();
    if (e) `CHK(status_protect_low[1], 1'b0)
  endtask

  // Set protection, then try one program or erase command
  task automatic prot(input logic [4:0] bp, input logic cp,
    input logic [2:0] c, input logic [23:0] a, input logic e);
    logic ok;
    sw(SEL_LOW, {1'b0, bp, 2'h0}, 1'b1);
    sw(SEL_MID, {1'b0, cp, 6'h00}, 1'b1);
    cmd(CMD_WRITE_UNLOCK, 2'h0, 24'h0, 8'h00, ok);
    cmd(c, 2'h0, a, 8'h00, ok);
    `CHK(ok, e)
    `CHK(op_start, e)
    if (e) `CHK(op_addr, a)
    if (e) `CHK(op_code, c)
    idle();
  endtask

  task automatic t_start();
    `CHK(status_protect_low, 8'h00)
    `CHK(status_protect_mid, 8'h00)
    `CHK(status_config_high, 8'h20)
    `CHK(wp_pin_is_data, 1'b0)
  endtask

  task automatic t_regs();
    logic ok;
    cmd(CMD_STATUS_WRITE, SEL_LOW, 24'h0, 8'h1c, ok);
    `CHK(ok, 1'b0)
    `CHK(status_protect_low, 8'h00)
    `CHK(cmd_refused, 1'b1)
    sw(SEL_HIGH, 8'hff, 1'b1);
    `CHK(status_config_high, 8'he1)
    `CHK(hold_pin_is_reset, 1'b1)
    `CHK(output_strength, 2'h3)
    `CHK(dummy_cycle_select, 1'b1)
    sw(SEL_HIGH, 8'h20, 1'b1);
    sw(SEL_LOW, 8'h07, 1'b1);
    `CHK(status_protect_low, 8'h04)
    sw(2'h0, 8'h00, 1'b0);
    cmd(CMD_WRITE_LOCK, 2'h0, 24'h0, 8'h00, ok);
    `CHK(status_protect_low[1], 1'b0)
  endtask

  task automatic t_busy();
    logic ok;
    lat = 8'h14;
    sw(SEL_LOW, 8'h00, 1'b1);
    cmd(CMD_WRITE_UNLOCK, 2'h0, 24'h0, 8'h00, ok);
    cmd(CMD_PAGE_WRITE, 2'h0, 24'h000100, 8'h00, ok);
    `CHK(status_protect_low, 8'h03)
    cmd(CMD_WRITE_UNLOCK, 2'h0, 24'h0, 8'h00, ok);
    `CHK(ok, 1'b0)
    idle();
    `CHK(status_protect_low, 8'h00)
    lat = 8'h02;
  endtask

  task automatic t_prot();
    prot(5'h01, 1'b0, CMD_PAGE_WRITE, 24'hfc0000, 1'b0);
    prot(5'h01, 1'b0, CMD_PAGE_WRITE, 24'hfbffff, 1'b1);
    prot(5'h09, 1'b0, CMD_FOUR_KB_WIPE, 24'h03ffff, 1'b0);
    prot(5'h09, 1'b0, CMD_BLOCK_WIPE, 24'h040000, 1'b1);
    prot(5'h11, 1'b0, CMD_PAGE_WRITE, 24'hfff000, 1'b0);
    prot(5'h11, 1'b0, CMD_PAGE_WRITE, 24'hffefff, 1'b1);
    prot(5'h01, 1'b1, CMD_PAGE_WRITE, 24'hfbffff, 1'b0);
    prot(5'h01, 1'b1, CMD_BLOCK_WIPE, 24'hfc0000, 1'b1);
    prot(5'h19, 1'b1, CMD_FOUR_KB_WIPE, 24'h000fff, 1'b1);
    prot(5'h19, 1'b1, CMD_PAGE_WRITE, 24'h001000, 1'b0);
    prot(5'h00, 1'b1, CMD_PAGE_WRITE, 24'h000000, 1'b0);
    prot(5'h07, 1'b1, CMD_PAGE_WRITE, 24'hffffff, 1'b1);
    prot(5'h00, 1'b0, CMD_CHIP_WIPE, 24'h0, 1'b1);
    prot(5'h07, 1'b1, CMD_CHIP_WIPE, 24'h0, 1'b1);
    prot(5'h01, 1'b0, CMD_CHIP_WIPE, 24'h0, 1'b0);
    prot(5'h07, 1'b0, CMD_CHIP_WIPE, 24'h0, 1'b0);
  endtask

  // Lock modes walked in order; the permanent lock must come last
  task automatic t_lock();
    logic ok;
    sw(SEL_MID, 8'h00, 1'b1);
    sw(SEL_LOW, 8'h80, 1'b1);
    wp_n = 1'b0;
    sw(SEL_LOW, 8'h84, 1'b0);
    `CHK(status_protect_low, 8'h82)
    wp_n = 1'b1;
    sw(SEL_LOW, 8'h84, 1'b1);
    sw(SEL_LOW, 8'h00, 1'b1);
    sw(SEL_MID, 8'h01, 1'b1);
    sw(SEL_LOW, 8'h00, 1'b0);
    pulse(power_cycle);
    `CHK(status_protect_mid, 8'h00)
    wp_n = 1'b0;
    sw(SEL_LOW, 8'h00, 1'b1);
    wp_n = 1'b1;
    sw(SEL_MID, 8'h02, 1'b1);
    `CHK(hold_pin_is_data, 1'b1)
    `CHK(wp_pin_is_data, 1'b1)
    sw(SEL_MID, 8'h08, 1'b1);
    sw(SEL_MID, 8'h00, 1'b1);
    `CHK(security_lock, 3'h1)
    pulse(erase_suspend);
    pulse(program_suspend);
    `CHK(status_protect_mid, 8'h8c)
    pulse(op_resume);
    `CHK(status_protect_mid, 8'h08)
    cmd(CMD_WRITE_UNLOCK, 2'h0, 24'h0, 8'h00, ok);
    pulse(soft_reset);
    `CHK(status_protect_low, 8'h00)
    sw(SEL_LOW, 8'h80, 1'b1);
    sw(SEL_MID, 8'h09, 1'b1);
    pulse(power_cycle);
    sw(SEL_LOW, 8'h00, 1'b0);
    `CHK(status_protect_mid, 8'h09)
  endtask

  task automatic test_done();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence after 12 cycles of reset
  initial begin
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_start();
    t_regs();
    t_busy();
    t_prot();
    t_lock();
    test_done();
  end

  // Watchdog well past the several hundred cycles the tests need
  initial begin
    #2000000;
    fails++;
    test_done();
  end
endmodule
